//--- logic/ataf_pkg.sv
// What this block does
// - Primary status read clears interrupt; alternate does not
// - Status byte layout, reset value only busy set
// - Busy while device owns registers; commands blocked
// - Other status bits undefined while busy reads one
// - Ready flag clear until device accepts commands
// - Corrected flag set; multi-sector read continues
// - Error flag set when previous command failed
// - Host flags a retry for any command ending with error
// - Device control writable at all times, even busy
// - Device control layout; bits 7-4 ignored
// - Soft reset holds device until bit cleared
// - Interrupt disable bit suppresses interrupt request
// - Interrupt disable forced zero at every reset
// - Readback bit 6 low during write operation
// - Readback bits 5-2 are inverted head select
// - Readback bits 1-0 low for selected drive
// - Command write starts execution immediately
// - Host loads parameters before writing command
// - Host issues commands only while busy reads zero
// - Access via two selects and three address lines
package ataf_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam int DW = 8;
    localparam logic [2:0] ADDR_STATUS_CMD = 3'h7;
    localparam logic [2:0] ADDR_ALT_DEVCTL = 3'h6;
    localparam logic [2:0] ADDR_DRV_ADDR = 3'h7;

    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DWF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_CORRECTED_ERROR_FLAG = 2;
    localparam int ST_ZERO = 1;
    localparam int ST_ERR = 0;
    localparam logic [7:0] STATUS_RST = 8'h80;

    // ----------------------------------------
    // Device control fields
    // ----------------------------------------
    localparam int DC_ONE = 3;
    localparam int DC_SRST = 2;
    localparam int DC_IRQ_DIS = 1;
    localparam logic [7:0] DEVCTL_RST = 8'h08;

    // ----------------------------------------
    // Drive address readback fields
    // ----------------------------------------
    localparam int DA_WTG = 6;
    localparam int DA_HS_HI = 5;
    localparam int DA_HS_LO = 2;
    localparam int DA_DS1 = 1;
    localparam int DA_DS0 = 0;
    localparam logic [7:0] DRV_ADDR_RST = 8'h7E;

    // ----------------------------------------
    // Host cycle timing, in REF_CLK cycles
    // ----------------------------------------
    localparam logic [3:0] HOST_SETUP_CYC = 4'h2;
    localparam logic [3:0] HOST_STROBE_CYC = 4'h8;
    localparam logic [3:0] HOST_HOLD_CYC = 4'h2;

endpackage

//--- logic/ataf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ataf_if;
    import ataf_pkg::*;
    logic command_block_select_n;
    logic control_block_select_n;
    logic [2:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] hdata;
    logic hdata_oe_n;
    logic [7:0] ddata;
    logic ddata_oe_n;
    logic intrq;
    logic [7:0] data;

    // ----------------------------------------
    // Shared data bus level
    // ----------------------------------------
    assign data = !ddata_oe_n ? ddata : (!hdata_oe_n ? hdata : 8'hFF);

    modport dev (
        input command_block_select_n, control_block_select_n, addr, rd_n, wr_n, data,
        output ddata, ddata_oe_n, intrq
    );
    modport host (
        output command_block_select_n, control_block_select_n, addr, rd_n, wr_n,
        output hdata, hdata_oe_n,
        input data, intrq
    );
endinterface
`default_nettype wire

//--- logic/ataf_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ataf_dev
    import ataf_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CE,
    ataf_if.dev BUS,
    input wire logic DEV_READY,
    input wire logic CMD_DONE,
    input wire logic CMD_ERROR,
    input wire logic WRITE_FAULT,
    input wire logic CORRECTED_ERROR_FLAG_EVENT,
    input wire logic XFER_REQ,
    input wire logic WRITE_ACTIVE,
    input wire logic [3:0] HEAD_SEL,
    input wire logic DRIVE_SEL,
    input wire logic DRIVE_ACTIVE,
    output logic CMD_VALID,
    output logic [7:0] CMD_CODE,
    output logic SOFT_RESET,
    output logic IRQ_DISABLE,
    output logic BUSY
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        DEV_BOOT,
        DEV_IDLE,
        DEV_EXEC,
        DEV_SRST
    } ataf_dev_mode_e;

    typedef struct packed {
        logic cs_cmd_s1;
        logic cs_cmd_s2;
        logic cs_ctl_s1;
        logic cs_ctl_s2;
        logic [2:0] addr_s1;
        logic [2:0] addr_s2;
        logic rd_s1;
        logic rd_s2;
        logic rd_s3;
        logic wr_s1;
        logic wr_s2;
        logic wr_s3;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        ataf_dev_mode_e mode;
        logic srst;
        logic irq_dis;
        logic write_fault_flag;
        logic corrected_error_flag;
        logic err;
        logic irq_pend;
        logic [7:0] ddata;
        logic ddata_oe_n;
        logic intrq;
        logic cmd_valid;
        logic [7:0] cmd_code;
        logic busy;
    } ataf_dev_s;

    localparam ataf_dev_s DEV_RST = '{
        cs_cmd_s1: 1'b1,
        cs_cmd_s2: 1'b1,
        cs_ctl_s1: 1'b1,
        cs_ctl_s2: 1'b1,
        addr_s1: 3'h0,
        addr_s2: 3'h0,
        rd_s1: 1'b1,
        rd_s2: 1'b1,
        rd_s3: 1'b1,
        wr_s1: 1'b1,
        wr_s2: 1'b1,
        wr_s3: 1'b1,
        dat_s1: 8'h00,
        dat_s2: 8'h00,
        mode: DEV_BOOT,
        srst: DEVCTL_RST[DC_SRST],
        irq_dis: DEVCTL_RST[DC_IRQ_DIS],
        write_fault_flag: 1'b0,
        corrected_error_flag: 1'b0,
        err: 1'b0,
        irq_pend: 1'b0,
        ddata: STATUS_RST,
        ddata_oe_n: 1'b1,
        intrq: 1'b0,
        cmd_valid: 1'b0,
        cmd_code: 8'h00,
        busy: 1'b1
    };

    ataf_dev_s st_r;
    ataf_dev_s st_nxt;

    // ----------------------------------------
    // Read images
    // ----------------------------------------
    function automatic logic [7:0] status_byte(input ataf_dev_s s, input logic ready,
                                               input logic transfer_request_flag);
        logic [7:0] v;
        logic rdy;
        v = 8'h00;
        rdy = ready && (s.mode != DEV_BOOT) && (s.mode != DEV_SRST);
        v[ST_BSY] = (s.mode != DEV_IDLE);
        v[ST_RDY] = rdy;
        v[ST_DWF] = s.write_fault_flag;
        v[ST_DSC] = rdy;
        v[ST_DRQ] = transfer_request_flag;
        v[ST_CORRECTED_ERROR_FLAG] = s.corrected_error_flag;
        v[ST_ZERO] = 1'b0;
        v[ST_ERR] = s.err;
        return v;
    endfunction

    function automatic logic [7:0] drv_addr_byte(input logic wr_act, input logic [3:0] hs,
                                                 input logic dsel, input logic dact);
        logic [7:0] v;
        v = 8'h00;
        v[DA_WTG] = !wr_act;
        v[DA_HS_HI:DA_HS_LO] = ~hs;
        v[DA_DS1] = !(dact && dsel);
        v[DA_DS0] = !(dact && !dsel);
        return v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic wr_fall;
    logic rd_fall;
    logic sel_cmd;
    logic sel_ctl;
    logic cmd_wr;
    logic ctl_wr;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd_valid = 1'b0;
        st_nxt.cs_cmd_s1 = BUS.command_block_select_n;
        st_nxt.cs_cmd_s2 = st_r.cs_cmd_s1;
        st_nxt.cs_ctl_s1 = BUS.control_block_select_n;
        st_nxt.cs_ctl_s2 = st_r.cs_ctl_s1;
        st_nxt.addr_s1 = BUS.addr;
        st_nxt.addr_s2 = st_r.addr_s1;
        st_nxt.rd_s1 = BUS.rd_n;
        st_nxt.rd_s2 = st_r.rd_s1;
        st_nxt.rd_s3 = st_r.rd_s2;
        st_nxt.wr_s1 = BUS.wr_n;
        st_nxt.wr_s2 = st_r.wr_s1;
        st_nxt.wr_s3 = st_r.wr_s2;
        st_nxt.dat_s1 = BUS.data;
        st_nxt.dat_s2 = st_r.dat_s1;

        wr_fall = st_r.wr_s3 && !st_r.wr_s2;
        rd_fall = st_r.rd_s3 && !st_r.rd_s2;
        sel_cmd = !st_r.cs_cmd_s2 && st_r.cs_ctl_s2;
        sel_ctl = st_r.cs_cmd_s2 && !st_r.cs_ctl_s2;
        cmd_wr = wr_fall && sel_cmd && (st_r.addr_s2 == ADDR_STATUS_CMD);
        ctl_wr = wr_fall && sel_ctl && (st_r.addr_s2 == ADDR_ALT_DEVCTL);

        // Device control, accepted in every mode
        if (ctl_wr) begin
            st_nxt.srst = st_r.dat_s2[DC_SRST];
            st_nxt.irq_dis = st_r.dat_s2[DC_IRQ_DIS];
        end

        case (st_r.mode)
            DEV_BOOT: begin
                if (DEV_READY) begin
                    st_nxt.mode = DEV_IDLE;
                end
            end
            DEV_IDLE: begin
                if (cmd_wr) begin
                    st_nxt.mode = DEV_EXEC;
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd_code = st_r.dat_s2;
                    st_nxt.err = 1'b0;
                    st_nxt.corrected_error_flag = 1'b0;
                    st_nxt.write_fault_flag = 1'b0;
                end
            end
            DEV_EXEC: begin
                if (CMD_DONE) begin
                    st_nxt.mode = DEV_IDLE;
                    st_nxt.err = CMD_ERROR;
                    st_nxt.irq_pend = 1'b1;
                end
            end
            DEV_SRST: begin
                if (!st_r.srst) begin
                    st_nxt.mode = DEV_BOOT;
                end
            end
            default: begin
                st_nxt.mode = DEV_BOOT;
            end
        endcase

        // Sticky events win over the clear of a new command
        if (WRITE_FAULT) begin
            st_nxt.write_fault_flag = 1'b1;
        end
        if (CORRECTED_ERROR_FLAG_EVENT) begin
            st_nxt.corrected_error_flag = 1'b1;
        end

        // Register reads
        if (rd_fall) begin
            if (sel_cmd && (st_r.addr_s2 == ADDR_STATUS_CMD)) begin
                st_nxt.ddata = status_byte(st_r, DEV_READY, XFER_REQ);
                st_nxt.ddata_oe_n = 1'b0;
                if (!(st_r.mode == DEV_EXEC && CMD_DONE)) begin
                    st_nxt.irq_pend = 1'b0;
                end
            end else if (sel_ctl && (st_r.addr_s2 == ADDR_ALT_DEVCTL)) begin
                st_nxt.ddata = status_byte(st_r, DEV_READY, XFER_REQ);
                st_nxt.ddata_oe_n = 1'b0;
            end else if (sel_ctl && (st_r.addr_s2 == ADDR_DRV_ADDR)) begin
                st_nxt.ddata = drv_addr_byte(WRITE_ACTIVE, HEAD_SEL, DRIVE_SEL, DRIVE_ACTIVE);
                st_nxt.ddata_oe_n = 1'b0;
            end
        end else if (st_r.rd_s2) begin
            st_nxt.ddata_oe_n = 1'b1;
        end

        // Soft reset overrides mode, flags and interrupt state while held; reads and control writes still served
        if (st_nxt.srst) begin
            st_nxt.mode = DEV_SRST;
            st_nxt.irq_dis = 1'b0;
            st_nxt.irq_pend = 1'b0;
            st_nxt.err = 1'b0;
            st_nxt.corrected_error_flag = 1'b0;
            st_nxt.write_fault_flag = 1'b0;
            st_nxt.cmd_valid = 1'b0;
        end

        st_nxt.intrq = st_nxt.irq_pend && !st_nxt.irq_dis;
        st_nxt.busy = (st_nxt.mode != DEV_IDLE);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_r <= DEV_RST;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign BUS.ddata = st_r.ddata;
    assign BUS.ddata_oe_n = st_r.ddata_oe_n;
    assign BUS.intrq = st_r.intrq;
    assign CMD_VALID = st_r.cmd_valid;
    assign CMD_CODE = st_r.cmd_code;
    assign SOFT_RESET = st_r.srst;
    assign IRQ_DISABLE = st_r.irq_dis;
    assign BUSY = st_r.busy;

endmodule // ataf_dev
`default_nettype wire

//--- logic/ataf_host.sv
`timescale 1ns/1ps
`default_nettype none
module ataf_host
    import ataf_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CE,
    ataf_if.host BUS,
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic REQ_CTL,
    input wire logic [2:0] REQ_ADDR,
    input wire logic [7:0] REQ_WDATA,
    output logic REQ_BUSY,
    output logic RSP_DONE,
    output logic RSP_REFUSED,
    output logic [7:0] RSP_DATA,
    output logic DEV_BUSY_SEEN,
    output logic RETRY_NEEDED,
    output logic INTRQ_LEVEL
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        HST_IDLE,
        HST_SETUP,
        HST_STROBE,
        HST_HOLD
    } ataf_host_phase_e;

    typedef struct packed {
        ataf_host_phase_e phase;
        logic [3:0] cnt;
        logic wr;
        logic ctl;
        logic [2:0] addr;
        logic cs_cmd_n;
        logic cs_ctl_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] hdata;
        logic hdata_oe_n;
        logic [7:0] d_s1;
        logic [7:0] d_s2;
        logic irq_s1;
        logic irq_s2;
        logic dev_busy;
        logic cmd_pend;
        logic retry;
        logic done;
        logic refused;
        logic [7:0] rdata;
        logic req_busy;
    } ataf_host_s;

    localparam ataf_host_s HOST_RST = '{
        phase: HST_IDLE, cnt: 4'h0, wr: 1'b0, ctl: 1'b0, addr: 3'h0,
        cs_cmd_n: 1'b1, cs_ctl_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        hdata: 8'h00, hdata_oe_n: 1'b1, d_s1: 8'h00, d_s2: 8'h00,
        irq_s1: 1'b0, irq_s2: 1'b0, dev_busy: STATUS_RST[ST_BSY],
        cmd_pend: 1'b0, retry: 1'b0, done: 1'b0, refused: 1'b0, rdata: 8'h00,
        req_busy: 1'b0
    };

    ataf_host_s st_r;
    ataf_host_s st_nxt;

    function automatic logic is_status(input logic ctl, input logic [2:0] a);
        return ctl ? (a == ADDR_ALT_DEVCTL) : (a == ADDR_STATUS_CMD);
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.refused = 1'b0;
        st_nxt.d_s1 = BUS.data;
        st_nxt.d_s2 = st_r.d_s1;
        st_nxt.irq_s1 = BUS.intrq;
        st_nxt.irq_s2 = st_r.irq_s1;
        case (st_r.phase)
            HST_IDLE: begin
                if (REQ) begin
                    if (REQ_WRITE && !REQ_CTL && REQ_ADDR == ADDR_STATUS_CMD
                        && st_r.dev_busy) begin
                        st_nxt.refused = 1'b1;
                        st_nxt.done = 1'b1;
                    end else begin
                        st_nxt.phase = HST_SETUP;
                        st_nxt.cnt = HOST_SETUP_CYC;
                        st_nxt.wr = REQ_WRITE;
                        st_nxt.ctl = REQ_CTL;
                        st_nxt.addr = REQ_ADDR;
                        st_nxt.cs_cmd_n = REQ_CTL;
                        st_nxt.cs_ctl_n = !REQ_CTL;
                        st_nxt.hdata = REQ_WDATA;
                        st_nxt.hdata_oe_n = !REQ_WRITE;
                    end
                end
            end
            HST_SETUP: begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1) begin
                    st_nxt.phase = HST_STROBE;
                    st_nxt.cnt = HOST_STROBE_CYC;
                    st_nxt.rd_n = st_r.wr;
                    st_nxt.wr_n = !st_r.wr;
                end
            end
            HST_STROBE: begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1) begin
                    st_nxt.phase = HST_HOLD;
                    st_nxt.cnt = HOST_HOLD_CYC;
                    st_nxt.rd_n = 1'b1;
                    st_nxt.wr_n = 1'b1;
                    if (!st_r.wr) begin
                        st_nxt.rdata = st_r.d_s2;
                    end
                end
            end
            HST_HOLD: begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1) begin
                    st_nxt.phase = HST_IDLE;
                    st_nxt.cs_cmd_n = 1'b1;
                    st_nxt.cs_ctl_n = 1'b1;
                    st_nxt.hdata_oe_n = 1'b1;
                    st_nxt.done = 1'b1;
                    if (st_r.wr && !st_r.ctl && st_r.addr == ADDR_STATUS_CMD) begin
                        st_nxt.dev_busy = 1'b1;
                        st_nxt.cmd_pend = 1'b1;
                        st_nxt.retry = 1'b0;
                    end else if (!st_r.wr && is_status(st_r.ctl, st_r.addr)) begin
                        st_nxt.dev_busy = st_r.rdata[ST_BSY];
                        if (st_r.cmd_pend && !st_r.rdata[ST_BSY]) begin
                            st_nxt.retry = st_r.rdata[ST_ERR];
                            st_nxt.cmd_pend = 1'b0;
                        end
                    end
                end
            end
            default: begin
                st_nxt.phase = HST_IDLE;
            end
        endcase
        st_nxt.req_busy = (st_nxt.phase != HST_IDLE);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_r <= HOST_RST;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign BUS.command_block_select_n = st_r.cs_cmd_n;
    assign BUS.control_block_select_n = st_r.cs_ctl_n;
    assign BUS.addr = st_r.addr;
    assign BUS.rd_n = st_r.rd_n;
    assign BUS.wr_n = st_r.wr_n;
    assign BUS.hdata = st_r.hdata;
    assign BUS.hdata_oe_n = st_r.hdata_oe_n;
    assign REQ_BUSY = st_r.req_busy;
    assign RSP_DONE = st_r.done;
    assign RSP_REFUSED = st_r.refused;
    assign RSP_DATA = st_r.rdata;
    assign DEV_BUSY_SEEN = st_r.dev_busy;
    assign RETRY_NEEDED = st_r.retry;
    assign INTRQ_LEVEL = st_r.irq_s2;

endmodule // ataf_host
`default_nettype wire

//--- bench/ataf_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ataf_sva (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic command_block_select_n,
    input wire logic control_block_select_n,
    input wire logic [2:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic hdata_oe_n,
    input wire logic [7:0] ddata,
    input wire logic ddata_oe_n,
    input wire logic intrq
);
    logic reg_read;
    logic one_sel;
    logic cmd7;
    assign cmd7 = !command_block_select_n && addr == 3'h7;
    assign one_sel = command_block_select_n != control_block_select_n;
    assign reg_read = !rd_n && (cmd7 || (!control_block_select_n && addr[2:1] == 2'h3));
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Bus rules
    // ----------------------------------------
    a_read_drive: assert property ($fell(rd_n) && reg_read |-> ##3 !ddata_oe_n)
        else $error("register read not driven");
    a_drive_cause: assert property ($fell(ddata_oe_n) |-> $past(reg_read, 3))
        else $error("data driven without read");
    a_read_release: assert property ($rose(rd_n) |-> ##3 ddata_oe_n)
        else $error("data bus not released");
    a_status_zero: assert property (!ddata_oe_n && !rd_n && cmd7 |-> !ddata[1])
        else $error("status bit 1 not zero");
    a_primary_clear: assert property ($fell(rd_n) && cmd7 && intrq |-> ##[3:5] !intrq)
        else $error("status read kept interrupt");
    a_alt_keep: assert property ($fell(rd_n) && !control_block_select_n && addr == 3'h6
        && intrq |-> intrq [*8])
        else $error("alternate read dropped interrupt");
    a_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
        else $error("write strobe width wrong");
    a_write_hold: assert property (!wr_n |-> $stable(addr) && !hdata_oe_n && one_sel)
        else $error("write cycle unstable");
    a_read_clean: assert property (!rd_n |-> wr_n && hdata_oe_n && one_sel)
        else $error("read cycle malformed");
    a_bus_single: assert property (!ddata_oe_n |-> hdata_oe_n)
        else $error("bus driven by both ends");
    c_irq_cleared: cover property (intrq ##1 !intrq);
    c_ctl_write: cover property ($fell(wr_n) && !control_block_select_n);
    c_dev_drive: cover property ($fell(ddata_oe_n));
endmodule // ataf_sva
`default_nettype wire

//--- bench/tb_ata_task_file_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ata_task_file_status_control;
    import ataf_pkg::*;
    logic ref_clk, rst_n, req, req_write, req_ctl, dev_ready, cmd_done, cmd_error;
    logic write_fault, corrected_error_flag_event, xfer_req, write_active, drive_sel, drive_active;
    logic cmd_valid, soft_reset, irq_disable, busy, rsp_done, rsp_refused;
    logic retry_needed, intrq_level, req_busy, dev_busy_seen;
    logic [2:0] req_addr;
    logic [3:0] head_sel;
    logic [7:0] req_wdata, cmd_code, rsp_data, cmds;
    logic [6:0] vec [3] = '{7'h20, 7'h75, 7'h0A};
    logic [7:0] dra_exp [3] = '{8'h7E, 8'h29, 8'h57};
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ataf_if bus();
    ataf_dev u_ataf_dev (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'h1), .BUS(bus),
        .DEV_READY(dev_ready), .CMD_DONE(cmd_done), .CMD_ERROR(cmd_error),
        .WRITE_FAULT(write_fault), .CORRECTED_ERROR_FLAG_EVENT(corrected_error_flag_event), .XFER_REQ(xfer_req),
        .WRITE_ACTIVE(write_active), .HEAD_SEL(head_sel), .DRIVE_SEL(drive_sel),
        .DRIVE_ACTIVE(drive_active), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .SOFT_RESET(soft_reset), .IRQ_DISABLE(irq_disable), .BUSY(busy));
    ataf_host u_ataf_host (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'h1), .BUS(bus),
        .REQ(req), .REQ_WRITE(req_write), .REQ_CTL(req_ctl), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_BUSY(req_busy), .RSP_DONE(rsp_done),
        .RSP_REFUSED(rsp_refused), .RSP_DATA(rsp_data), .DEV_BUSY_SEEN(dev_busy_seen),
        .RETRY_NEEDED(retry_needed), .INTRQ_LEVEL(intrq_level));
    ataf_sva u_ataf_sva (.REF_CLK(ref_clk), .RST_N(rst_n),
        .command_block_select_n(bus.command_block_select_n),
        .control_block_select_n(bus.control_block_select_n), .addr(bus.addr),
        .rd_n(bus.rd_n), .wr_n(bus.wr_n), .hdata_oe_n(bus.hdata_oe_n), .ddata(bus.ddata),
        .ddata_oe_n(bus.ddata_oe_n), .intrq(bus.intrq));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cmds <= 8'h00;
        end else if (cmd_valid === 1'h1) begin
            cmds <= cmds + 8'h01;
        end
    end
    // ----------------------------------------
    // Checks and host access
    // ----------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] want, input string what);
        comparisons++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic check1(input logic got, input logic want, input string what);
        check8({7'h00, got}, {7'h00, want}, what);
    endtask
    task automatic xfer(input logic w, c, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic r);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= 1'h1;
        req_write <= w;
        req_ctl <= c;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(posedge ref_clk);
            req <= 1'h0;
            #1;
            n++;
        end while (rsp_done !== 1'h1 && n < 40);
        check1(n < 40, 1'h1, "host response");
        check1(req_busy, 1'h0, "host idle at done");
        q = rsp_data;
        r = rsp_refused;
    endtask
    task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] m, e, input string s);
        logic [7:0] q;
        logic r;
        xfer(1'h0, c, a, 8'h00, q, r);
        check8(q & m, e, s);
    endtask
    task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d, input logic e);
        logic [7:0] q;
        logic r;
        xfer(1'h1, c, a, d, q, r);
        check1(r, e, "refusal");
    endtask
    task automatic fw(input logic [3:0] ev);
        @(posedge ref_clk);
        {cmd_done, cmd_error, write_fault, corrected_error_flag_event} <= ev;
        @(posedge ref_clk);
        {cmd_done, cmd_error, write_fault, corrected_error_flag_event} <= 4'h0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {ref_clk, rst_n, req, req_write, req_ctl, dev_ready, cmd_done, cmd_error} = 8'h00;
        {write_fault, corrected_error_flag_event, xfer_req, write_active, drive_sel} = 5'h00;
        drive_active = 1'h1;
        head_sel = 4'h0;
        req_addr = 3'h0;
        req_wdata = 8'h00;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        #1;
        rd(1'h0, 3'h7, 8'hFF, STATUS_RST, "status at reset");
        check1(irq_disable, 1'h0, "disable at reset");
        check1(soft_reset, 1'h0, "soft reset at reset");
        wr(1'h0, 3'h7, 8'h20, 1'h1);
        check8(cmds, 8'h00, "command in boot");
        check1(dev_busy_seen, 1'h1, "host saw boot busy");
        @(posedge ref_clk);
        dev_ready <= 1'h1;
        end_test("reset");
        rd(1'h0, 3'h7, 8'hFF, 8'h50, "status ready");
        check1(dev_busy_seen, 1'h0, "host saw ready");
        wr(1'h0, 3'h7, 8'h20, 1'h0);
        check8(cmds, 8'h01, "command taken");
        check8(cmd_code, 8'h20, "command code");
        rd(1'h0, 3'h7, 8'h80, 8'h80, "status busy");
        wr(1'h0, 3'h7, 8'h30, 1'h1);
        wr(1'h1, 3'h6, 8'h0A, 1'h0);
        check1(irq_disable, 1'h1, "disable while busy");
        @(posedge ref_clk);
        xfer_req <= 1'h1;
        fw(4'h1);
        check1(busy, 1'h1, "corrected keeps command");
        fw(4'h2);
        fw(4'hC);
        check1(bus.intrq, 1'h0, "interrupt suppressed");
        wr(1'h1, 3'h6, 8'h08, 1'h0);
        check1(bus.intrq, 1'h1, "interrupt enabled");
        check1(intrq_level, 1'h1, "host sees interrupt");
        rd(1'h1, 3'h6, 8'hFF, 8'h7D, "alternate status");
        check1(bus.intrq, 1'h1, "alternate keeps interrupt");
        rd(1'h0, 3'h7, 8'hFF, 8'h7D, "primary status");
        check1(bus.intrq, 1'h0, "primary clears interrupt");
        check1(retry_needed, 1'h1, "retry flagged");
        @(posedge ref_clk);
        xfer_req <= 1'h0;
        end_test("command");
        wr(1'h0, 3'h7, 8'h20, 1'h0);
        check8(cmds, 8'h02, "retry taken");
        fw(4'h8);
        rd(1'h0, 3'h7, 8'hFF, 8'h50, "status clean");
        check1(retry_needed, 1'h0, "retry cleared");
        end_test("retry");
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            {write_active, drive_active, drive_sel, head_sel} <= vec[i];
            rd(1'h1, 3'h7, 8'hFF, dra_exp[i], "drive address");
        end
        end_test("readback");
        wr(1'h1, 3'h6, 8'h0E, 1'h0);
        check1(soft_reset, 1'h1, "soft reset set");
        check1(irq_disable, 1'h0, "disable forced");
        repeat (20) @(posedge ref_clk);
        #1;
        check1(soft_reset, 1'h1, "soft reset held");
        rd(1'h0, 3'h7, 8'h80, 8'h80, "busy in soft reset");
        wr(1'h1, 3'h6, 8'hF2, 1'h0);
        check1(soft_reset, 1'h0, "soft reset left");
        check1(irq_disable, 1'h1, "upper bits ignored");
        rd(1'h0, 3'h7, 8'hFF, 8'h50, "ready after reset");
        end_test("soft reset");
        stop_test();
    end
endmodule // tb_ata_task_file_status_control
`default_nettype wire
